// [shared/rilc_cfg.svh]
// Constants for the reset, interrupt and low-power controller.
// Assumes inclusion by bare name from the package and design modules.
`ifndef RILC_CFG_SVH
`define RILC_CFG_SVH

// Clock period in ns at 125 MHz.
`define RILC_CLK_NS        8
// Stabilization delay, in processor clock cycles.
`define RILC_POR_CYCLES    4064
// Vector addresses, low byte of each pair.
`define RILC_VEC_RESET     16'h1ffe
`define RILC_VEC_SWI       16'h1ffc
`define RILC_VEC_EXT       16'h1ffa
`define RILC_VEC_TIMER     16'h1ff8
// Reset value of the global mask bit.
`define RILC_MASK_RST      1'b1

`endif

// [shared/rilc_pkg.sv]
// Types for the reset, interrupt and low-power controller.
// Assumes rilc_cfg.svh is on the include path.
`include "rilc_cfg.svh"

package rilc_pkg;

  // Controller states.
  typedef enum logic [2:0] {
    RILC_RESET = 3'b000,
    RILC_RUN   = 3'b001,
    RILC_SVC   = 3'b010,
    RILC_STOP  = 3'b011,
    RILC_WAIT  = 3'b100
  } rilc_state_t;

  // Which vector is being served.
  typedef enum logic [1:0] {
    RILC_SRC_RESET = 2'b00,
    RILC_SRC_SWI   = 2'b01,
    RILC_SRC_EXT   = 2'b10,
    RILC_SRC_TIMER = 2'b11
  } rilc_src_t;

endpackage

// [shared/rilc_irq_if.sv]
// Interface between the controller and its external interrupt latch.
// Assumes one clock domain, mclk.
interface rilc_irq_if;
  logic pending;   // Latched external request.
  logic clear;     // Pulse: clear the latch.
  logic pin_level; // Synchronized pin level.

  modport latch (output pending, output pin_level, input clear);
  modport ctrl  (input pending, input pin_level, output clear);
endinterface

// [design/rilc_irq_latch.sv]
// External interrupt pin synchronizer and falling-edge latch.
// Assumes the pin is synchronous to mclk but still double-registered.
`include "rilc_cfg.svh"

module rilc_irq_latch
  import rilc_pkg::*;
#(
  parameter bit LEVEL_SENS = 1'b1 // Build option: level plus edge when set.
) (
  input  wire logic  mclk,
  input  wire logic  reset,
  input  wire logic  irq_n,
  rilc_irq_if.latch  irq
);

  // All state of this module.
  typedef struct packed {
    logic sync1;   // First synchronizer stage.
    logic sync2;   // Second synchronizer stage.
    logic prev;    // Previous synchronized level.
    logic pend;    // Latched request.
  } rilc_lat_t;

  rilc_lat_t cur_ff;
  rilc_lat_t nxt_cur;

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  // The edge detector compares the second stage with the previous level.
  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.sync1 = irq_n;
    nxt_cur.sync2 = cur_ff.sync1;
    nxt_cur.prev  = cur_ff.sync2;
    if (irq.clear) begin
      nxt_cur.pend = 1'b0;
    end
    if (cur_ff.prev && !cur_ff.sync2) begin
      nxt_cur.pend = 1'b1;
    end
    if (LEVEL_SENS && !cur_ff.sync2) begin
      nxt_cur.pend = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cur_ff <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, pend: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign irq.pending   = cur_ff.pend;
  assign irq.pin_level = cur_ff.sync2;

endmodule

// [design/rilc_ctrl.sv]
// Reset, interrupt arbitration and low-power control for an 8-bit core.
// Assumes the core pulses instr_done at each instruction boundary and
// stop_exec, wait_exec, swi_exec as it executes those instructions.
`include "rilc_cfg.svh"

// How it works
// - Reset from power-on, pin, or watchdog.
// - Hold reset 4064 cycles after power-up.
// - Stay reset while pin low after count.
// - Release on third clock after pin rises.
// - Watchdog reset restores prior operating mode.
// - Watchdog enable fixed at build time.
// - Interrupt saves registers, sets mask bit.
// - Hardware requests wait for instruction end.
// - Take interrupt only unmasked and enabled.
// - External pin beats timer.
// - Reset vectors 1FFE, sets mask.
// - Software trap ignores mask, vectors 1FFC.
// - Pin falling edge latched, synchronized, 1FFA.
// - Level-and-edge or edge-only build option.
// - Latch cleared early in service.
// - Any enabled timer flag vectors 1FF8.
// - Stop halts oscillators, timer, watchdog.
// - Stop clears timer requests and prescaler.
// - Stop clears mask; exits on pin/reset.
// - Wait keeps clocks; any interrupt exits.
// - Wait clears mask, preserves the rest.
module rilc_ctrl
  import rilc_pkg::*;
#(
  parameter bit          WDOG_EN    = 1'b1,               // Build option.
  parameter bit          LEVEL_SENS = 1'b1,               // Build option.
  parameter int unsigned POR_CYCLES = `RILC_POR_CYCLES    // Stabilization delay.
) (
  input  wire logic        mclk,          // Processor clock.
  input  wire logic        reset,         // Power-on detector, active high.
  input  wire logic        reset_pin_n,   // External reset pin level.
  input  wire logic        wdog_timeout,  // Watchdog time-out pulse.
  input  wire logic        irq_n,         // External interrupt pin.
  input  wire logic [2:0]  timer_flags,   // Capture, compare, rollover flags.
  input  wire logic [2:0]  timer_enables, // Matching enables.
  input  wire logic        instr_done,    // Instruction boundary pulse.
  input  wire logic        swi_exec,      // Software trap at boundary.
  input  wire logic        stop_exec,     // Stop instruction executing.
  input  wire logic        wait_exec,     // Wait instruction executing.
  input  wire logic        rti_exec,      // Return from trap executing.
  input  wire logic        mask_set,      // Core sets mask bit.
  input  wire logic        mask_clr,      // Core clears mask bit.
  output logic             core_reset,    // Internal reset to the core.
  output logic             int_mask,      // Global interrupt mask bit.
  output logic             svc_start,     // Pulse: save registers and vector.
  output logic [15:0]      vector_addr,   // Vector being fetched.
  output logic             restore,       // Pulse: restore registers.
  output logic             osc_off,       // Oscillators stopped.
  output logic             cpu_halt,      // CPU suspended.
  output logic             timer_kill,    // Pulse: clear timer requests, prescaler.
  output logic             wdog_mode      // Mode kept across watchdog reset.
);

  localparam logic [12:0] POR_LAST = 13'(POR_CYCLES - 1);

  // ----------------------------------------------------------------
  // Latch interface.
  // ----------------------------------------------------------------
  rilc_irq_if irq ();

  rilc_irq_latch #(
    .LEVEL_SENS (LEVEL_SENS)
  ) u_latch (
    .mclk  (mclk),
    .reset (reset),
    .irq_n (irq_n),
    .irq   (irq)
  );

  // All controller state.
  typedef struct packed {
    rilc_state_t st;        // Controller state.
    logic [12:0] por_cnt;   // Stabilization counter.
    logic        por_done;  // Delay finished.
    logic        pin_s1;    // Reset pin first stage.
    logic        pin_s2;    // Reset pin second stage.
    logic        core_rst;  // Internal reset.
    logic        mask;      // Global mask bit.
    logic        svc;       // Service pulse.
    logic [15:0] vec;       // Vector address.
    logic        rest;      // Restore pulse.
    logic        osc_off;   // Oscillator off.
    logic        halt;      // CPU halted.
    logic        tkill;     // Timer clear pulse.
    logic        clr;       // Latch clear pulse.
    logic        wmode;     // Mode held over watchdog reset.
  } rilc_ctl_t;

  rilc_ctl_t cur_ff;
  rilc_ctl_t nxt_cur;

  logic timer_req; // Any enabled timer flag.
  logic ext_req;   // External request pending.

  // ----------------------------------------------------------------
  // Request sources.
  // ----------------------------------------------------------------
  always_comb begin
    timer_req = |(timer_flags & timer_enables);
    ext_req   = irq.pending;
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.svc    = 1'b0;
    nxt_cur.rest   = 1'b0;
    nxt_cur.tkill  = 1'b0;
    nxt_cur.clr    = 1'b0;
    nxt_cur.pin_s1 = reset_pin_n;
    nxt_cur.pin_s2 = cur_ff.pin_s1;

    // Mask bit updates from the core.
    if (mask_clr) begin
      nxt_cur.mask = 1'b0;
    end
    if (mask_set) begin
      nxt_cur.mask = 1'b1;
    end

    if (!cur_ff.por_done) begin
      if (cur_ff.por_cnt == POR_LAST) begin
        nxt_cur.por_done = 1'b1;
      end else begin
        nxt_cur.por_cnt = cur_ff.por_cnt + 13'h1;
      end
    end

    case (cur_ff.st)
      RILC_RESET: begin
        nxt_cur.core_rst = 1'b1;
        nxt_cur.osc_off  = 1'b0;
        nxt_cur.halt     = 1'b0;
        nxt_cur.mask     = `RILC_MASK_RST;
        nxt_cur.vec      = `RILC_VEC_RESET;
        if (cur_ff.por_done && cur_ff.pin_s2) begin
          nxt_cur.core_rst = 1'b0;
          nxt_cur.svc      = 1'b1;
          nxt_cur.st       = RILC_RUN;
        end
      end
      RILC_RUN: begin
        if (instr_done) begin
          if (swi_exec) begin
            nxt_cur.svc  = 1'b1;
            nxt_cur.vec  = `RILC_VEC_SWI;
            nxt_cur.mask = 1'b1;
            nxt_cur.st   = RILC_SVC;
          end else if (!cur_ff.mask && ext_req) begin
            nxt_cur.svc  = 1'b1;
            nxt_cur.vec  = `RILC_VEC_EXT;
            nxt_cur.mask = 1'b1;
            nxt_cur.clr  = 1'b1;
            nxt_cur.st   = RILC_SVC;
          end else if (!cur_ff.mask && timer_req) begin
            nxt_cur.svc  = 1'b1;
            nxt_cur.vec  = `RILC_VEC_TIMER;
            nxt_cur.mask = 1'b1;
            nxt_cur.st   = RILC_SVC;
          end else if (stop_exec) begin
            nxt_cur.osc_off = 1'b1;
            nxt_cur.halt    = 1'b1;
            nxt_cur.tkill   = 1'b1;
            nxt_cur.mask    = 1'b0;
            nxt_cur.wmode   = 1'b0;
            nxt_cur.st      = RILC_STOP;
          end else if (wait_exec) begin
            nxt_cur.halt  = 1'b1;
            nxt_cur.mask  = 1'b0;
            nxt_cur.wmode = 1'b1;
            nxt_cur.st    = RILC_WAIT;
          end
        end
        if (rti_exec) begin
          nxt_cur.rest = 1'b1;
        end
      end
      RILC_SVC: begin
        // Register stacking happens in the core; one cycle here.
        nxt_cur.st = RILC_RUN;
      end
      RILC_STOP: begin
        if (ext_req) begin
          nxt_cur.osc_off = 1'b0;
          nxt_cur.halt    = 1'b0;
          nxt_cur.svc     = 1'b1;
          nxt_cur.vec     = `RILC_VEC_EXT;
          nxt_cur.mask    = 1'b1;
          nxt_cur.clr     = 1'b1;
          nxt_cur.st      = RILC_SVC;
        end
      end
      RILC_WAIT: begin
        if (ext_req || timer_req) begin
          nxt_cur.halt = 1'b0;
          nxt_cur.svc  = 1'b1;
          nxt_cur.vec  = ext_req ? `RILC_VEC_EXT : `RILC_VEC_TIMER;
          nxt_cur.clr  = ext_req;
          nxt_cur.mask = 1'b1;
          nxt_cur.st   = RILC_SVC;
        end
      end
      default: begin
        nxt_cur.st = RILC_RESET;
      end
    endcase

    if (!cur_ff.pin_s2) begin
      nxt_cur.st       = RILC_RESET;
      nxt_cur.core_rst = 1'b1;
      nxt_cur.wmode    = 1'b0;
    end
    if (WDOG_EN && wdog_timeout && !cur_ff.osc_off) begin
      nxt_cur.st       = RILC_RESET;
      nxt_cur.core_rst = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  // power-on source
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cur_ff <= '{st: RILC_RESET, por_cnt: 13'h0, por_done: 1'b0,
                  pin_s1: 1'b1, pin_s2: 1'b1, core_rst: 1'b1,
                  mask: `RILC_MASK_RST, svc: 1'b0, vec: `RILC_VEC_RESET,
                  rest: 1'b0, osc_off: 1'b0, halt: 1'b0, tkill: 1'b0,
                  clr: 1'b0, wmode: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flip-flop.
  // ----------------------------------------------------------------
  assign irq.clear   = cur_ff.clr;
  assign core_reset  = cur_ff.core_rst;
  assign int_mask    = cur_ff.mask;
  assign svc_start   = cur_ff.svc;
  assign vector_addr = cur_ff.vec;
  assign restore     = cur_ff.rest;
  assign osc_off     = cur_ff.osc_off;
  assign cpu_halt    = cur_ff.halt;
  assign timer_kill  = cur_ff.tkill;
  assign wdog_mode   = cur_ff.wmode;

endmodule

// [dv/rilc_ctrl_sva.sv]
// Assertion checker for the reset, interrupt and low-power controller.
// Assumes it is bound to rilc_ctrl and sees only that module's ports.
module rilc_ctrl_sva #(
  parameter bit          WDOG_EN    = 1'b1,
  parameter int unsigned POR_CYCLES = 8
) (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        reset_pin_n,
  input wire logic        wdog_timeout,
  input wire logic        instr_done,
  input wire logic        core_reset,
  input wire logic        int_mask,
  input wire logic        svc_start,
  input wire logic [15:0] vector_addr,
  input wire logic        osc_off,
  input wire logic        cpu_halt,
  input wire logic        timer_kill
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  int unsigned por_ff; // Cycles counted since power-on release.

  // Counts the stabilization time after the power-on reset drops.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) por_ff <= 0;
    else if (por_ff < POR_CYCLES) por_ff <= por_ff + 1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_por_hold: assert property (por_ff < POR_CYCLES |-> core_reset)
    else $error("core left reset early");
  a_pin_reset: assert property (!reset_pin_n |-> ##[0:3] core_reset)
    else $error("reset pin ignored");
  a_wdog_reset: assert property (WDOG_EN && wdog_timeout && !osc_off |-> ##[0:3] core_reset)
    else $error("watchdog time-out ignored");
  a_reset_vector: assert property ($fell(core_reset) |-> svc_start && int_mask && vector_addr == 16'h1ffe)
    else $error("bad start after reset");
  a_svc_mask: assert property (svc_start |-> int_mask)
    else $error("service without mask set");
  a_hw_unmasked: assert property (svc_start && vector_addr inside {16'h1ffa, 16'h1ff8} |-> !$past(int_mask))
    else $error("hardware request taken while masked");
  a_svc_boundary: assert property (svc_start && !$past(core_reset) && !$past(cpu_halt) |-> $past(instr_done))
    else $error("service outside a boundary");
  a_stop_entry: assert property ($rose(osc_off) |-> cpu_halt && timer_kill && !int_mask)
    else $error("stop entry incomplete");
endmodule

bind rilc_ctrl rilc_ctrl_sva #(.WDOG_EN(WDOG_EN), .POR_CYCLES(POR_CYCLES)) u_sva (
  .mclk, .reset, .reset_pin_n, .wdog_timeout, .instr_done, .core_reset, .int_mask,
  .svc_start, .vector_addr, .osc_off, .cpu_halt, .timer_kill);

// [dv/rilc_far_model.sv]
// Model of the reset pin, interrupt pin and timer flag source.
// Assumes the bench requests pin activity one cycle at a time.
module rilc_far_model (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       fire_irq,
  input  wire logic       rst_req,
  input  wire logic [2:0] flag_set,
  input  wire logic [2:0] flag_clr,
  input  wire logic       timer_kill,
  output logic            irq_n,
  output logic            reset_pin_n,
  output logic [2:0]      timer_flags
);
  int low_cnt; // Cycles the interrupt pin stays low.

  // Short low pulse on the pin; flags drop when the controller kills them.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_cnt     <= 0;
      timer_flags <= 3'h0;
    end else begin
      if (fire_irq) low_cnt <= 2;
      else if (low_cnt != 0) low_cnt <= low_cnt - 1;
      timer_flags <= (timer_kill ? 3'h0 : timer_flags & ~flag_clr) | flag_set;
    end
  end
  assign irq_n = (low_cnt == 0);
  assign reset_pin_n = !rst_req;
endmodule

// [dv/rilc_ctrl_tb.sv]
// Self-checking bench for the controller with the pin and timer model.
// Assumes a shortened stabilization count of 8 cycles.
module rilc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 8;
  // Selectors for the one-cycle input pulses.
  localparam int P_MCLR = 0, P_MSET = 1, P_RET = 2, P_FIRE = 3;
  localparam int P_WDOG = 4, P_FCLR = 5, P_FSET = 6;
  logic mclk = 0, reset = 1, wdog_timeout = 0, instr_done = 0, swi_exec = 0;
  logic stop_exec = 0, wait_exec = 0, rti_exec = 0, mask_set = 0, mask_clr = 0;
  logic fire_irq = 0, rst_req = 0, reset_pin_n, irq_n, core_reset, int_mask;
  logic svc_start, restore, osc_off, cpu_halt, timer_kill, wdog_mode;
  logic [2:0] timer_enables = 3'h7, flag_set = 3'h0, flag_clr = 3'h0, timer_flags;
  logic [15:0] vector_addr;
  logic [15:0] exp_q[$]; // Vectors the model expects, in order.
  int bad_count = 0, comparisons = 0, cycles = 0, i;

  always #4 mclk = ~mclk;

  rilc_ctrl #(.POR_CYCLES(POR)) DUT (.mclk, .reset, .reset_pin_n, .wdog_timeout, .irq_n,
    .timer_flags, .timer_enables, .instr_done, .swi_exec, .stop_exec, .wait_exec,
    .rti_exec, .mask_set, .mask_clr, .core_reset, .int_mask, .svc_start, .vector_addr,
    .restore, .osc_off, .cpu_halt, .timer_kill, .wdog_mode);
  rilc_far_model u_far (.mclk, .reset, .fire_irq, .rst_req, .flag_set, .flag_clr,
    .timer_kill, .irq_n, .reset_pin_n, .timer_flags);

  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Puts v on the input chosen by s; b picks the timer flag bit.
  task automatic drive(int s, int b, logic v);
    case (s)
      P_MCLR:  mask_clr     = v;
      P_MSET:  mask_set     = v;
      P_RET:   rti_exec     = v;
      P_FIRE:  fire_irq     = v;
      P_WDOG:  wdog_timeout = v;
      P_FCLR:  flag_clr[b]  = v;
      default: flag_set[b]  = v;
    endcase
  endtask
  // Raises the chosen input for exactly one clock edge.
  task automatic pulse(int s, int b = 0);
    drive(s, b, 1'b1);
    tick();
    drive(s, b, 1'b0);
  endtask
  // Boundary with {trap, stop, wait}; returns in the cycle after the taking edge.
  task automatic bound(logic [2:0] k);
    swi_exec   = k[2];
    stop_exec  = k[1];
    wait_exec  = k[0];
    instr_done = 1'b1;
    tick();
    instr_done = 1'b0;
    swi_exec   = 1'b0;
    stop_exec  = 1'b0;
    wait_exec  = 1'b0;
  endtask
  task automatic drain();
    for (int n = 0; n < 40 && exp_q.size() > 0; n++) tick();
    chk("pending", 16'h0, 16'(exp_q.size()));
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Every service is matched against the expected vector queue.
  always @(negedge mclk) begin
    if (svc_start === 1'b1) begin
      if (exp_q.size() == 0) chk("svc", 16'h0, 16'h1);
      else chk("vector", exp_q.pop_front(), vector_addr);
    end
  end
  // Cuts a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(30159));
    rst_req = 1'b1;
    exp_q.push_back(16'h1ffe);
    tick(20);
    reset = 1'b0;
    tick(POR + 6);
    chk("held", 16'h1, core_reset);
    rst_req = 1'b0;
    drain();
    chk("mask", 16'h1, int_mask);
    for (i = 0; i < 3; i++) begin
      timer_enables = 3'h7;
      flag_set = 3'h1 << i;
      tick();
      flag_set = 3'h0;
      bound(3'h0);
      pulse(P_MCLR);
      timer_enables = 3'h7 ^ (3'h1 << i);
      bound(3'h0);
      tick(4);
      exp_q.push_back(16'h1ff8);
      timer_enables = 3'($urandom) | (3'h1 << i);
      bound(3'h0);
      drain();
      chk("mask", 16'h1, int_mask);
      pulse(P_FCLR, i);
    end
    timer_enables = 3'h7;
    flag_set = 3'h2;
    pulse(P_FIRE);
    flag_set = 3'h0;
    pulse(P_MCLR);
    tick(6);
    exp_q.push_back(16'h1ffa);
    bound(3'h0);
    drain();
    pulse(P_MCLR);
    exp_q.push_back(16'h1ff8);
    bound(3'h0);
    drain();
    pulse(P_FCLR, 1);
    pulse(P_MSET);
    exp_q.push_back(16'h1ffc);
    bound(3'h4);
    drain();
    pulse(P_RET);
    chk("restore", 16'h1, restore);
    tick(3);
    bound(3'h2);
    chk("stop", 16'h7, {13'h0, osc_off, cpu_halt, timer_kill});
    chk("mask", 16'h0, int_mask);
    tick(5);
    exp_q.push_back(16'h1ffa);
    pulse(P_FIRE);
    drain();
    chk("osc", 16'h0, osc_off);
    tick(3);
    bound(3'h1);
    chk("wait", 16'h1, {14'h0, osc_off, cpu_halt});
    chk("mask", 16'h0, int_mask);
    exp_q.push_back(16'h1ff8);
    pulse(P_FSET, 0);
    drain();
    chk("halt", 16'h0, cpu_halt);
    pulse(P_FCLR, 0);
    exp_q.push_back(16'h1ffe);
    pulse(P_WDOG);
    drain();
    chk("mode", 16'h1, wdog_mode);
    exp_q.push_back(16'h1ffe);
    rst_req = 1'b1;
    tick(2);
    rst_req = 1'b0;
    drain();
    chk("mode", 16'h0, wdog_mode);
    stop_test();
  end
endmodule
